// ===== design/cmp_ctrl_regs.sv
// Core power and system control register bank behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [cmp_pkg::CMP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cmp_pkg::CMP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic core_light_sleep,
  output logic [cmp_pkg::CMP_BANKS-1:0] bank_sleep_enable,
  output logic [cmp_pkg::CMP_BANKS-1:0] bank_shutdown_enable,
  output logic ext_mem_fifo_disable,
  output logic core_clock_gating_off,
  output logic local_mem_shutdown_allow,
  output logic accelerator_irq_enable,
  output logic prefetch_buffer_invalidate,
  output logic uninit_read_returns_zero,
  output logic data_port_prefetch_enable,
  output logic instr_port_prefetch_enable,
  output logic [cmp_pkg::CMP_BLOCKS-1:0] block_width_select,
  output logic [23:0] vector_table_base,
  output logic software_reset_request
);
  logic [cmp_pkg::CMP_ADDR_W-1:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic [31:0] power_q;
  logic [31:0] sleep_q;
  logic [31:0] shutdown_q;
  logic [31:0] control_q;
  logic software_reset_request_arm_q;
  logic do_write;
  logic write_hit;
  logic [31:0] strb_mask;
  logic [31:0] read_word;
  logic read_hit;
  logic dec_light;
  logic [cmp_pkg::CMP_BANKS-1:0] dec_sleep;
  logic [cmp_pkg::CMP_BANKS-1:0] dec_shutdown;
  logic [cmp_pkg::CMP_BLOCKS-1:0] dec_wide;
  logic [23:0] dec_vector;

  // Address and data are caught independently, so either may come first
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_q <= 1'b0;
  end

  // Ready is dropped while a half is held or a response waits
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                       && !do_write;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                      && !do_write;
    end
  end

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  // Byte enables widened to a bit mask
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_strb
      assign strb_mask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
  endgenerate

  always_comb
  begin
    write_hit = 1'b1;
    case (awaddr_q[cmp_pkg::CMP_ADDR_W-1:2])
      cmp_pkg::CMP_OFF_GLOBAL_POWER[cmp_pkg::CMP_ADDR_W-1:2]: write_hit = 1'b1;
      cmp_pkg::CMP_OFF_BANK_SLEEP[cmp_pkg::CMP_ADDR_W-1:2]: write_hit = 1'b1;
      cmp_pkg::CMP_OFF_BANK_SHUTDOWN[cmp_pkg::CMP_ADDR_W-1:2]: write_hit = 1'b1;
      cmp_pkg::CMP_OFF_SYSTEM_CONTROL[cmp_pkg::CMP_ADDR_W-1:2]: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  // Write response one cycle after both halves are in hand
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cmp_pkg::CMP_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_hit ? cmp_pkg::CMP_RESP_OKAY : cmp_pkg::CMP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Stored words; only defined bits take a write
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      power_q <= '0;
      sleep_q <= '0;
      shutdown_q <= '0;
      control_q <= cmp_pkg::CMP_SC_RESET;
    end
    else
    begin
      if (do_write && awaddr_q == cmp_pkg::CMP_OFF_GLOBAL_POWER)
        power_q <= (power_q & ~(strb_mask & cmp_pkg::CMP_SLEEP_MASK))
                   | (wdata_q & strb_mask & cmp_pkg::CMP_SLEEP_MASK);
      if (do_write && awaddr_q == cmp_pkg::CMP_OFF_BANK_SLEEP)
        sleep_q <= (sleep_q & ~(strb_mask & cmp_pkg::CMP_BANK_MASK))
                   | (wdata_q & strb_mask & cmp_pkg::CMP_BANK_MASK);
      if (do_write && awaddr_q == cmp_pkg::CMP_OFF_BANK_SHUTDOWN)
        shutdown_q <= (shutdown_q & ~(strb_mask & cmp_pkg::CMP_BANK_MASK))
                      | (wdata_q & strb_mask & cmp_pkg::CMP_BANK_MASK);
      if (do_write && awaddr_q == cmp_pkg::CMP_OFF_SYSTEM_CONTROL)
        control_q <= (control_q & ~(strb_mask & cmp_pkg::CMP_SC_MASK))
                     | (wdata_q & strb_mask & cmp_pkg::CMP_SC_MASK);
    end
  end

  // Software reset is armed on the write and fires one cycle later,
  // so whatever follows the write still completes first
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      software_reset_request_arm_q <= 1'b0;
      software_reset_request <= 1'b0;
    end
    else
    begin
      software_reset_request_arm_q <= do_write && awaddr_q == cmp_pkg::CMP_OFF_SYSTEM_CONTROL
                    && wstrb_q[cmp_pkg::CMP_SC_SW_RESET / 8]
                    && wdata_q[cmp_pkg::CMP_SC_SW_RESET];
      software_reset_request <= software_reset_request_arm_q;
    end
  end

  // Invalidate is a one-cycle pulse on each write that sets bit 16
  always_ff @(posedge clock)
  begin
    if (rst)
      prefetch_buffer_invalidate <= 1'b0;
    else
      prefetch_buffer_invalidate <= do_write
                                    && awaddr_q == cmp_pkg::CMP_OFF_SYSTEM_CONTROL
                                    && wstrb_q[cmp_pkg::CMP_SC_PREFETCH_BUFFER_INVALIDATE / 8]
                                    && wdata_q[cmp_pkg::CMP_SC_PREFETCH_BUFFER_INVALIDATE];
  end

  cmp_field_decode u_decode (
    .power_word(power_q),
    .sleep_word(sleep_q),
    .shutdown_word(shutdown_q),
    .control_word(control_q),
    .light_sleep(dec_light),
    .bank_sleep(dec_sleep),
    .bank_shutdown(dec_shutdown),
    .block_wide(dec_wide),
    .vector_base(dec_vector)
  );

  // Control outputs registered so they come straight from flops
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_light_sleep <= 1'b0;
      bank_sleep_enable <= '0;
      bank_shutdown_enable <= '0;
      ext_mem_fifo_disable <= 1'b0;
      core_clock_gating_off <= 1'b0;
      local_mem_shutdown_allow <= 1'b0;
      accelerator_irq_enable <= 1'b0;
      uninit_read_returns_zero <= 1'b0;
      data_port_prefetch_enable <= 1'b0;
      instr_port_prefetch_enable <= 1'b0;
      block_width_select <= '0;
      vector_table_base <= cmp_pkg::CMP_VT_BOOT_ADDR;
    end
    else
    begin
      core_light_sleep <= dec_light;
      bank_sleep_enable <= dec_sleep;
      bank_shutdown_enable <= dec_shutdown;
      ext_mem_fifo_disable <= control_q[cmp_pkg::CMP_SC_FIFO_DIS];
      core_clock_gating_off <= control_q[cmp_pkg::CMP_SC_CG_OFF];
      local_mem_shutdown_allow <= control_q[cmp_pkg::CMP_SC_SD_ALLOW];
      accelerator_irq_enable <= control_q[cmp_pkg::CMP_SC_ACC_IRQ];
      uninit_read_returns_zero <= control_q[cmp_pkg::CMP_SC_UNINIT_ZERO];
      data_port_prefetch_enable <= control_q[cmp_pkg::CMP_SC_DPORT_PFB];
      instr_port_prefetch_enable <= control_q[cmp_pkg::CMP_SC_IPORT_PFB];
      block_width_select <= dec_wide;
      vector_table_base <= dec_vector;
    end
  end

  // Read mux; the invalidate bit is stored but reads back as zero, and the reset bit is never stored
  always_comb
  begin
    read_hit = 1'b1;
    case (s_axi_araddr[cmp_pkg::CMP_ADDR_W-1:2])
      cmp_pkg::CMP_OFF_GLOBAL_POWER[cmp_pkg::CMP_ADDR_W-1:2]: read_word = power_q;
      cmp_pkg::CMP_OFF_BANK_SLEEP[cmp_pkg::CMP_ADDR_W-1:2]: read_word = sleep_q;
      cmp_pkg::CMP_OFF_BANK_SHUTDOWN[cmp_pkg::CMP_ADDR_W-1:2]: read_word = shutdown_q;
      cmp_pkg::CMP_OFF_SYSTEM_CONTROL[cmp_pkg::CMP_ADDR_W-1:2]:
        read_word = control_q & ~(32'h1 << cmp_pkg::CMP_SC_PREFETCH_BUFFER_INVALIDATE);
      default:
      begin
        read_word = '0;
        read_hit = 1'b0;
      end
    endcase
  end

  // Reads answer one cycle after acceptance; one at a time
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cmp_pkg::CMP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_hit ? cmp_pkg::CMP_RESP_OKAY : cmp_pkg::CMP_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end
endmodule : cmp_ctrl_regs
`default_nettype wire

// ===== design/cmp_field_decode.sv
// Decode of stored control words into the light sleep, bank enable, width select and vector base outputs
`timescale 1ns/100ps
`default_nettype none
module cmp_field_decode (
  input wire logic [31:0] power_word,
  input wire logic [31:0] sleep_word,
  input wire logic [31:0] shutdown_word,
  input wire logic [31:0] control_word,
  output logic light_sleep,
  output logic [cmp_pkg::CMP_BANKS-1:0] bank_sleep,
  output logic [cmp_pkg::CMP_BANKS-1:0] bank_shutdown,
  output logic [cmp_pkg::CMP_BLOCKS-1:0] block_wide,
  output logic [23:0] vector_base
);
  // Reserved sleep codes fall back to no sleep
  assign light_sleep = (power_word[1:0] == cmp_pkg::CMP_SLEEP_LIGHT);
  // One enable per bank, bit n to bank n
  genvar g;
  generate
    for (g = 0; g < cmp_pkg::CMP_BANKS; g++)
    begin : g_bank
      assign bank_sleep[g] = sleep_word[g];
      assign bank_shutdown[g] = shutdown_word[g];
    end
    for (g = 0; g < cmp_pkg::CMP_BLOCKS; g++)
    begin : g_blk
      assign block_wide[g] = control_word[cmp_pkg::CMP_SC_WIDTH_LO + g];
    end
  endgenerate
  // External map wins over internal if both are set; neither means boot ROM
  always_comb
  begin
    if (control_word[cmp_pkg::CMP_SC_VT_EXT])
      vector_base = cmp_pkg::CMP_VT_EXT_ADDR;
    else if (control_word[cmp_pkg::CMP_SC_VT_INT])
      vector_base = cmp_pkg::CMP_VT_INT_ADDR;
    else
      vector_base = cmp_pkg::CMP_VT_BOOT_ADDR;
  end
endmodule : cmp_field_decode
`default_nettype wire

// ===== design/cmp_pkg.sv
// Constants shared by the core power and system control register bank
package cmp_pkg;
  // Register byte offsets
  localparam logic [11:0] CMP_OFF_GLOBAL_POWER = 12'h000;
  localparam logic [11:0] CMP_OFF_BANK_SLEEP = 12'h004;
  localparam logic [11:0] CMP_OFF_BANK_SHUTDOWN = 12'h008;
  localparam logic [11:0] CMP_OFF_SYSTEM_CONTROL = 12'h00c;
  localparam int CMP_ADDR_W = 12;
  localparam int CMP_BANKS = 4;
  localparam int CMP_BLOCKS = 4;
  // Field positions in the system control register
  localparam int CMP_SC_FIFO_DIS = 30;
  localparam int CMP_SC_SD_ALLOW = 26;
  localparam int CMP_SC_CG_OFF = 25;
  localparam int CMP_SC_ACC_IRQ = 17;
  localparam int CMP_SC_PREFETCH_BUFFER_INVALIDATE = 16;
  localparam int CMP_SC_UNINIT_ZERO = 15;
  localparam int CMP_SC_DPORT_PFB = 14;
  localparam int CMP_SC_IPORT_PFB = 13;
  localparam int CMP_SC_WIDTH_LO = 9;
  localparam int CMP_SC_VT_EXT = 3;
  localparam int CMP_SC_VT_INT = 2;
  localparam int CMP_SC_SW_RESET = 0;
  // Writable masks and the system control reset value
  localparam logic [31:0] CMP_SC_MASK = 32'h4603_fe0c;
  localparam logic [31:0] CMP_SC_RESET = 32'h0000_0000;
  localparam logic [31:0] CMP_BANK_MASK = 32'h0000_000f;
  localparam logic [31:0] CMP_SLEEP_MASK = 32'h0000_0003;
  // Sleep codes
  localparam logic [1:0] CMP_SLEEP_NONE = 2'h0;
  localparam logic [1:0] CMP_SLEEP_LIGHT = 2'h1;
  // Vector table base addresses
  localparam logic [23:0] CMP_VT_EXT_ADDR = 24'h40_0000;
  localparam logic [23:0] CMP_VT_INT_ADDR = 24'h90_0000;
  localparam logic [23:0] CMP_VT_BOOT_ADDR = 24'h50_0000;
  // AXI responses
  localparam logic [1:0] CMP_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMP_RESP_SLVERR = 2'h2;
endpackage : cmp_pkg

// ===== verification/cmp_ctrl_regs_asserts.sv
// Port-level assertions for the core power and system control register bank
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl_regs_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic core_light_sleep,
  input wire logic [3:0] bank_sleep_enable,
  input wire logic [3:0] bank_shutdown_enable,
  input wire logic ext_mem_fifo_disable,
  input wire logic core_clock_gating_off,
  input wire logic local_mem_shutdown_allow,
  input wire logic prefetch_buffer_invalidate,
  input wire logic uninit_read_returns_zero,
  input wire logic data_port_prefetch_enable,
  input wire logic instr_port_prefetch_enable,
  input wire logic [3:0] block_width_select,
  input wire logic [23:0] vector_table_base,
  input wire logic software_reset_request
);
  logic [11:0] ra_q;
  logic rd_ok;
  logic rs;
  // Read data arrives later than its address, so keep the address
  always_ff @(posedge clock)
  begin
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  end
  // Good read replies; outputs settle before any reply can come back
  assign rd_ok = s_axi_rvalid && s_axi_rresp == 2'h0;
  assign rs = rd_ok && ra_q == 12'h00c;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_sleep_code: assert property (rd_ok && ra_q == 12'h000 |->
    core_light_sleep == (s_axi_rdata == 32'h1)) else $error("light sleep output wrong");
  chk_bank_sleep: assert property (rd_ok && ra_q == 12'h004 |->
    s_axi_rdata == {28'h0, bank_sleep_enable}) else $error("bank sleep output wrong");
  chk_bank_down: assert property (rd_ok && ra_q == 12'h008 |->
    s_axi_rdata == {28'h0, bank_shutdown_enable}) else $error("bank shutdown output wrong");
  chk_fifo_clock_flags: assert property (rs |-> {s_axi_rdata[30],
    s_axi_rdata[26:25]} == {ext_mem_fifo_disable, local_mem_shutdown_allow,
    core_clock_gating_off}) else $error("fifo or clock flag wrong");
  chk_prefetch_flags: assert property (rs |-> s_axi_rdata[15:13] ==
    {uninit_read_returns_zero, data_port_prefetch_enable, instr_port_prefetch_enable})
    else $error("prefetch flag wrong");
  chk_width_select: assert property (rs |->
    s_axi_rdata[12:9] == block_width_select) else $error("width select wrong");
  chk_vector_base: assert property (rs |-> vector_table_base ==
    (s_axi_rdata[3] ? 24'h40_0000 : s_axi_rdata[2] ? 24'h90_0000 : 24'h50_0000))
    else $error("vector base wrong");
  chk_undef_zero: assert property (rs |->
    (s_axi_rdata & ~32'h4602_fe0c) == 32'h0) else $error("undefined bits not zero");
  chk_boot_vector: assert property ($fell(rst) |->
    vector_table_base == 24'h50_0000) else $error("vector base not boot after reset");
  chk_software_reset_request_pulse: assert property (software_reset_request |=>
    !software_reset_request) else $error("software reset pulse too long");
  chk_inval_pulse: assert property ($rose(prefetch_buffer_invalidate) |=>
    $fell(prefetch_buffer_invalidate)) else $error("invalidate pulse too long");
  cov_software_reset_request: cover property (software_reset_request);
  cov_inval: cover property (prefetch_buffer_invalidate);
  cov_err_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : cmp_ctrl_regs_asserts
bind cmp_ctrl_regs cmp_ctrl_regs_asserts u_chk (.*);
`default_nettype wire

// ===== verification/tb_cmp_ctrl_regs.sv
// Self-checking bench for the core power and system control register bank
`timescale 1ns/100ps
`default_nettype none
module tb_cmp_ctrl_regs;
  logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, bank_sleep_enable, bank_shutdown_enable, block_width_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic core_light_sleep, ext_mem_fifo_disable, core_clock_gating_off, local_mem_shutdown_allow;
  logic accelerator_irq_enable, prefetch_buffer_invalidate, uninit_read_returns_zero;
  logic data_port_prefetch_enable, instr_port_prefetch_enable, software_reset_request;
  logic [23:0] vector_table_base;
  int errors, compares, n, software_reset_request_n, inval_n, k;

  cmp_ctrl_regs dut_u (.*);

  // Free-running 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Count pulse cycles; a pulse lost between reads would otherwise go unseen
  always @(posedge clock)
  begin
    if (software_reset_request === 1'b1) software_reset_request_n++;
    if (prefetch_buffer_invalidate === 1'b1) inval_n++;
  end

  task test_done();
    begin
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk

  // One clock of a bounded wait; a hang ends the run
  task step();
    begin
      @(posedge clock);
      n++;
      if (n > 100)
      begin
        errors++;
        test_done();
      end
    end
  endtask : step

  // Address and data offered together, each dropped once its own ready is seen
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      n = 0;
      while (!(ad && wd))
      begin
        step();
        if (!ad && s_axi_awready === 1'b1)
        begin
          ad = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!wd && s_axi_wready === 1'b1)
        begin
          wd = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (s_axi_bvalid !== 1'b1) step();
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
    end
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      step();
      while (s_axi_arready !== 1'b1) step();
      s_axi_arvalid <= 1'b0;
      step();
      while (s_axi_rvalid !== 1'b1) step();
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
    end
  endtask : rd

  // Only defined control bits read back; bits 16 and 0 act and read zero
  task sc(input logic [31:0] w, input logic [23:0] vb);
    logic [31:0] m;
    begin
      m = w & 32'h4602_fe0c;
      wr(12'h00c, w, 2'h0);
      rd(12'h00c, m, 2'h0);
      chk(ext_mem_fifo_disable, m[30]);
      chk({core_clock_gating_off, local_mem_shutdown_allow}, {m[25], m[26]});
      chk(accelerator_irq_enable, m[17]);
      chk(uninit_read_returns_zero, m[15]);
      chk({data_port_prefetch_enable, instr_port_prefetch_enable}, m[14:13]);
      chk(block_width_select, m[12:9]);
      chk(vector_table_base, vb);
    end
  endtask : sc

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {errors, compares, software_reset_request_n, inval_n, n} = {5{32'h0}};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    chk(vector_table_base, 24'h50_0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h000, 32'hffff_fffc | i, 2'h0);
      rd(12'h000, i, 2'h0);
      chk(core_light_sleep, i == 1);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h004, 32'hffff_fff0 | (1 << i), 2'h0);
      wr(12'h008, 1 << (3 - i), 2'h0);
      rd(12'h004, 1 << i, 2'h0);
      rd(12'h008, 1 << (3 - i), 2'h0);
      chk(bank_sleep_enable, 1 << i);
      chk(bank_shutdown_enable, 1 << (3 - i));
    end
    k = inval_n;
    sc(32'hffff_fffe, 24'h40_0000);
    chk(inval_n - k, 1);
    chk(software_reset_request_n, 0);
    sc(32'h0000_0004, 24'h90_0000);
    sc(32'h0000_2208, 24'h40_0000);
    sc(32'h0000_0001, 24'h50_0000);
    chk(software_reset_request_n, 1);
    wr(12'h010, 32'hffff_ffff, 2'h2);
    rd(12'h010, 32'h0, 2'h2);
    rd(12'h004, 32'h8, 2'h0);
    // Lane 0 masked: the bank sleep enables keep their old value
    s_axi_wstrb <= 4'he;
    wr(12'h004, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h004, 32'h8, 2'h0);
    chk(bank_sleep_enable, 4'h8);
    // Lane 2 masked: setting the invalidate bit must not pulse
    k = inval_n;
    s_axi_wstrb <= 4'hb;
    wr(12'h00c, 32'h0001_0000, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h00c, 32'h0, 2'h0);
    chk(inval_n - k, 0);
    // Reset again in mid-run: everything returns to its reset state
    sc(32'h0000_0004, 24'h90_0000);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(12'h00c, 32'h0, 2'h0);
    rd(12'h004, 32'h0, 2'h0);
    chk(vector_table_base, 24'h50_0000);
    test_done();
  end
endmodule : tb_cmp_ctrl_regs
`default_nettype wire
